/* File: logic/mtf_pkg.sv */
package mtf_pkg;
  // header layout: 6 bytes shifted in, unit id is the 7th
  localparam logic [2:0]  HDR_LAST      = 3'h6;
  localparam logic [15:0] PROTO_ID      = 16'h0000;
  localparam logic [15:0] MB_PORT       = 16'h01F6;  // 502
  // length covers unit id plus a PDU of at most 253 bytes (ADU 260)
  localparam logic [15:0] LEN_MIN       = 16'h0002;
  localparam logic [15:0] LEN_MAX       = 16'h00FE;
  localparam logic [15:0] LEN_RD        = 16'h0006;
  localparam logic [15:0] LEN_EXC       = 16'h0003;
  localparam logic [15:0] LEN_RSP_BASE  = 16'h0003;
  localparam logic [7:0]  FC_READ_HOLD  = 8'h03;
  localparam logic [7:0]  FC_EXC_FLAG   = 8'h80;
  localparam logic [15:0] QTY_MIN       = 16'h0001;
  localparam logic [15:0] QTY_MAX       = 16'h007D;
  localparam logic [16:0] NUM_HOLD_REGS = 17'h00100;
  localparam logic [7:0]  EXC_NONE      = 8'h00;
  localparam logic [7:0]  EXC_ILL_FUNC  = 8'h01;
  localparam logic [7:0]  EXC_ILL_ADDR  = 8'h02;
  localparam logic [7:0]  EXC_ILL_VALUE = 8'h03;
  // response byte positions
  localparam logic [3:0]  TX_LEN_LO     = 4'h5;
  localparam logic [3:0]  TX_UID        = 4'h6;
  localparam logic [3:0]  TX_FC         = 4'h7;
  localparam logic [3:0]  TX_END        = 4'h8;
  localparam logic [7:0]  PDU_FIELD_END = 8'h04;
  localparam int unsigned FIFO_WIDTH    = 9;
  localparam int unsigned FIFO_DEPTH    = 8;

  typedef enum logic [7:0] {
    ST_HDR    = 8'h01,
    ST_PDU    = 8'h02,
    ST_DROP   = 8'h04,
    ST_EVAL   = 8'h08,
    ST_TXHDR  = 8'h10,
    ST_RDREQ  = 8'h20,
    ST_RDWAIT = 8'h40,
    ST_TXDAT  = 8'h80
  } mtf_state_t;
endpackage : mtf_pkg

/* File: logic/mtf_framer.sv */
`timescale 1ns/1ps

module mtf_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side, registered
  output logic                  outValid_ff,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData_ff
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  // full and empty are taken from the count, never guessed
  assign inReady = (cnt_ff != (AW+1)'(DEPTH));
  assign push    = inValid && inReady;
  assign pop     = (cnt_ff != '0) && (!outValid_ff || outReady);

  // storage has no reset; pointers, count and output stage carry the state
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      cnt_ff   <= '0;
    end else begin
      if (push) wrPtr_ff <= wrPtr_ff + 1'b1;
      if (pop) rdPtr_ff <= rdPtr_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // output stage so the drain side sees flops only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      outValid_ff <= 1'b0;
      outData_ff  <= '0;
    end else if (pop) begin
      outValid_ff <= 1'b1;
      outData_ff  <= mem[rdPtr_ff];
    end else if (outReady) begin
      outValid_ff <= 1'b0;
    end
  end
endmodule : mtf_fifo

module mtf_framer (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // request bytes from the tcp stack
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxLast,
  input  wire logic [15:0] rxDstPort,
  output logic             rxReady_ff,
  // response bytes to the tcp stack
  output logic             txValid_ff,
  output logic [7:0]       txData_ff,
  output logic             txLast_ff,
  input  wire logic        txReady,
  // holding register read, data one cycle after request
  output logic             regRdReq_ff,
  output logic [15:0]      regRdAddr_ff,
  input  wire logic [15:0] regRdData
);
  mtf_pkg::mtf_state_t state_ff;
  mtf_pkg::mtf_state_t nxt_state;
  logic [47:0] hdr_ff;
  logic [7:0]  uid_ff;
  logic [7:0]  fc_ff;
  logic [31:0] pdu_ff;
  logic [2:0]  hdrCnt_ff;
  logic [7:0]  pduCnt_ff;
  logic [7:0]  exc_ff;
  logic [3:0]  txIdx_ff;
  logic [6:0]  regIdx_ff;
  logic [15:0] rdData_ff;
  logic        loByte_ff;
  logic        rxFire;
  logic        hdrOk;
  logic        pduEnd;
  logic        lastReg;
  logic        pushValid;
  logic        pushReady;
  logic [7:0]  pushByte;
  logic        pushLast;
  logic [15:0] tid;
  logic [15:0] pid;
  logic [15:0] len;
  logic [15:0] addr;
  logic [15:0] qty;
  logic [15:0] rspLen;

  // checks a complete request, first failing check wins
  function automatic logic [7:0] check_req(input logic [7:0] fc, input logic [15:0] ln,
                                           input logic [15:0] ad, input logic [15:0] qt);
    if (fc != mtf_pkg::FC_READ_HOLD) return mtf_pkg::EXC_ILL_FUNC;
    if (ln != mtf_pkg::LEN_RD || qt < mtf_pkg::QTY_MIN || qt > mtf_pkg::QTY_MAX)
      return mtf_pkg::EXC_ILL_VALUE;
    if ({1'b0, ad} + {1'b0, qt} > mtf_pkg::NUM_HOLD_REGS) return mtf_pkg::EXC_ILL_ADDR;
    return mtf_pkg::EXC_NONE;
  endfunction : check_req

  // response header byte at a given position
  function automatic logic [7:0] hdr_byte(input logic [3:0] idx);
    case (idx)
      4'h0: return tid[15:8];
      4'h1: return tid[7:0];
      4'h2: return pid[15:8];
      4'h3: return pid[7:0];
      4'h4: return rspLen[15:8];
      4'h5: return rspLen[7:0];
      4'h6: return uid_ff;
      4'h7: return (exc_ff != mtf_pkg::EXC_NONE) ? (fc_ff | mtf_pkg::FC_EXC_FLAG) : fc_ff;
      default: return (exc_ff != mtf_pkg::EXC_NONE) ? exc_ff : {qty[6:0], 1'b0};
    endcase
  endfunction : hdr_byte

  assign tid  = hdr_ff[47:32];
  assign pid  = hdr_ff[31:16];
  assign len  = hdr_ff[15:0];
  assign addr = pdu_ff[31:16];
  assign qty  = pdu_ff[15:0];
  assign rspLen = (exc_ff != mtf_pkg::EXC_NONE) ? mtf_pkg::LEN_EXC
                : mtf_pkg::LEN_RSP_BASE + {8'h00, qty[6:0], 1'b0};

  assign rxFire  = rxValid && rxReady_ff;
  assign hdrOk   = (pid == mtf_pkg::PROTO_ID) && (len >= mtf_pkg::LEN_MIN)
                && (len <= mtf_pkg::LEN_MAX) && (rxDstPort == mtf_pkg::MB_PORT);
  assign pduEnd  = rxFire && ({8'h00, pduCnt_ff} + mtf_pkg::LEN_MIN == len);
  assign lastReg = ({9'h000, regIdx_ff} + 16'h0001 == qty);

  // bytes offered to the response buffer; a full buffer stalls the walk
  always_comb begin
    pushValid = (state_ff == mtf_pkg::ST_TXHDR) || (state_ff == mtf_pkg::ST_TXDAT);
    if (state_ff == mtf_pkg::ST_TXDAT) begin
      pushByte = loByte_ff ? rdData_ff[7:0] : rdData_ff[15:8];
      pushLast = loByte_ff && lastReg;
    end else begin
      pushByte = hdr_byte(txIdx_ff);
      pushLast = (txIdx_ff == mtf_pkg::TX_END) && (exc_ff != mtf_pkg::EXC_NONE);
    end
  end

  // frame walk
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      mtf_pkg::ST_HDR: begin
        if (rxFire && hdrCnt_ff == mtf_pkg::HDR_LAST)
          nxt_state = rxLast ? mtf_pkg::ST_HDR : (hdrOk ? mtf_pkg::ST_PDU : mtf_pkg::ST_DROP);
      end
      mtf_pkg::ST_PDU: begin
        if (pduEnd) nxt_state = mtf_pkg::ST_EVAL;
        else if (rxFire && rxLast) nxt_state = mtf_pkg::ST_HDR;
      end
      mtf_pkg::ST_DROP: begin
        if (rxFire && rxLast) nxt_state = mtf_pkg::ST_HDR;
      end
      mtf_pkg::ST_EVAL: nxt_state = mtf_pkg::ST_TXHDR;
      mtf_pkg::ST_TXHDR: begin
        if (pushReady && txIdx_ff == mtf_pkg::TX_END)
          nxt_state = (exc_ff != mtf_pkg::EXC_NONE) ? mtf_pkg::ST_HDR : mtf_pkg::ST_RDREQ;
      end
      mtf_pkg::ST_RDREQ:  nxt_state = mtf_pkg::ST_RDWAIT;
      mtf_pkg::ST_RDWAIT: nxt_state = mtf_pkg::ST_TXDAT;
      mtf_pkg::ST_TXDAT: begin
        if (pushReady && loByte_ff) nxt_state = lastReg ? mtf_pkg::ST_HDR : mtf_pkg::ST_RDREQ;
      end
    endcase
  end

  // state and receive gate; taking no bytes while answering keeps one
  // request in flight at a time
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff   <= mtf_pkg::ST_HDR;
      rxReady_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      rxReady_ff <= (nxt_state == mtf_pkg::ST_HDR) || (nxt_state == mtf_pkg::ST_PDU)
                 || (nxt_state == mtf_pkg::ST_DROP);
    end
  end

  // header capture
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hdr_ff    <= '0;
      uid_ff    <= '0;
      hdrCnt_ff <= '0;
    end else if (rxFire && state_ff == mtf_pkg::ST_HDR) begin
      hdrCnt_ff <= (rxLast || hdrCnt_ff == mtf_pkg::HDR_LAST) ? 3'h0 : hdrCnt_ff + 1'b1;
      if (hdrCnt_ff == mtf_pkg::HDR_LAST) uid_ff <= rxData;
      else hdr_ff <= {hdr_ff[39:0], rxData};
    end
  end

  // PDU capture: code then four field bytes, the rest only counted
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fc_ff     <= '0;
      pdu_ff    <= '0;
      pduCnt_ff <= '0;
    end else if (state_ff == mtf_pkg::ST_HDR) begin
      pduCnt_ff <= '0;
    end else if (rxFire && state_ff == mtf_pkg::ST_PDU) begin
      pduCnt_ff <= pduCnt_ff + 1'b1;
      if (pduCnt_ff == '0) fc_ff <= rxData;
      else if (pduCnt_ff <= mtf_pkg::PDU_FIELD_END) pdu_ff <= {pdu_ff[23:0], rxData};
    end
  end

  // verdict and response walk counters
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      exc_ff    <= '0;
      txIdx_ff  <= '0;
      regIdx_ff <= '0;
      loByte_ff <= 1'b0;
    end else if (state_ff == mtf_pkg::ST_EVAL) begin
      exc_ff    <= check_req(fc_ff, len, addr, qty);
      txIdx_ff  <= '0;
      regIdx_ff <= '0;
      loByte_ff <= 1'b0;
    end else if (pushReady) begin
      if (state_ff == mtf_pkg::ST_TXHDR) txIdx_ff <= txIdx_ff + 1'b1;
      if (state_ff == mtf_pkg::ST_TXDAT) begin
        loByte_ff <= !loByte_ff;
        if (loByte_ff) regIdx_ff <= regIdx_ff + 1'b1;
      end
    end
  end

  // register fetch: one request, data taken the next cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      regRdReq_ff  <= 1'b0;
      regRdAddr_ff <= '0;
      rdData_ff    <= '0;
    end else begin
      regRdReq_ff <= (nxt_state == mtf_pkg::ST_RDREQ);
      // zero based address
      // the index steps on the same edge that leaves the data state, so count ahead there
      if (nxt_state == mtf_pkg::ST_RDREQ) begin
        regRdAddr_ff <= addr + {9'h000, regIdx_ff}
                      + ((state_ff == mtf_pkg::ST_TXDAT) ? 16'h0001 : 16'h0000);
      end
      if (state_ff == mtf_pkg::ST_RDWAIT) rdData_ff <= regRdData;
    end
  end

  // response buffer decouples the walk from a slow tcp stack
  logic inRdy;
  assign pushReady = pushValid && inRdy;

  mtf_fifo #(
    .WIDTH (mtf_pkg::FIFO_WIDTH),
    .DEPTH (mtf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .inValid     (pushValid),
    .inReady     (inRdy),
    .inData      ({pushLast, pushByte}),
    .outValid_ff (txValid_ff),
    .outReady    (txReady),
    .outData_ff  ({txLast_ff, txData_ff})
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_tid_echo: assert property (
    pushReady && state_ff == mtf_pkg::ST_TXHDR && txIdx_ff == 4'h0 |-> pushByte == tid[15:8])
    else $error("transaction id not echoed");
  a_pid_zero: assert property (
    state_ff == mtf_pkg::ST_PDU |-> pid == mtf_pkg::PROTO_ID)
    else $error("nonzero protocol id accepted");
  a_len_fresh: assert property (
    pushReady && state_ff == mtf_pkg::ST_TXHDR && txIdx_ff == mtf_pkg::TX_LEN_LO
    |-> pushByte == ((exc_ff != 8'h00) ? 8'h03 : 8'h03 + {qty[6:0], 1'b0}))
    else $error("response length wrong");
  a_uid_echo: assert property (
    pushReady && txIdx_ff == mtf_pkg::TX_UID && state_ff == mtf_pkg::ST_TXHDR
    |-> pushByte == $past(uid_ff, 4))
    else $error("unit id not echoed");
  a_exc_code: assert property (
    pushReady && state_ff == mtf_pkg::ST_TXHDR && txIdx_ff == mtf_pkg::TX_FC
    && exc_ff != 8'h00 |-> pushByte[7] && pushByte[6:0] == fc_ff[6:0])
    else $error("exception code byte wrong");
  a_len_limit: assert property (
    state_ff == mtf_pkg::ST_PDU |-> len >= 16'h0002 && len <= 16'h00FE)
    else $error("oversize frame accepted");
  a_port_gate: assert property (
    rxFire && state_ff == mtf_pkg::ST_HDR && hdrCnt_ff == 3'h6 && rxDstPort != 16'h01F6
    |=> state_ff != mtf_pkg::ST_PDU)
    else $error("foreign port served");
  a_rd_fetch: assert property (
    regRdReq_ff |=> ##1 rdData_ff == $past(regRdData) ##0
    (!pushReady || pushByte == rdData_ff[15:8]))
    else $error("register data order wrong");
  a_addr_zero: assert property (
    regRdReq_ff |-> regRdAddr_ff == addr + {9'h000, regIdx_ff})
    else $error("start address shifted");
  a_bad_func: assert property (
    state_ff == mtf_pkg::ST_EVAL && fc_ff != 8'h03 |=> exc_ff == 8'h01)
    else $error("unknown code not refused");
  a_qty_range: assert property (
    state_ff == mtf_pkg::ST_EVAL && fc_ff == 8'h03 && len == 16'h0006
    && (qty == 16'h0000 || qty > 16'h007D) |=> exc_ff == 8'h03)
    else $error("bad quantity not refused");
  a_public_only: assert property (
    state_ff == mtf_pkg::ST_RDREQ |-> fc_ff == 8'h03 && exc_ff == 8'h00)
    else $error("read started for refused request");

  c_read_done: cover property (state_ff == mtf_pkg::ST_TXDAT ##1 state_ff == mtf_pkg::ST_HDR);
  c_exception: cover property (pushReady && pushLast && state_ff == mtf_pkg::ST_TXHDR);
  c_dropped:   cover property (state_ff == mtf_pkg::ST_DROP ##1 state_ff == mtf_pkg::ST_HDR);
  c_stalled:   cover property (pushValid && !inRdy);
endmodule : mtf_framer

/* File: dv/mtf_hold_regs.sv */
`timescale 1ns/1ps

module mtf_hold_regs (
  // clock
  input  wire logic        clk_sys,
  // read port driven by the framer
  input  wire logic        regRdReq_ff,
  input  wire logic [15:0] regRdAddr_ff,
  output logic      [15:0] regRdData
);
  logic [15:0] lastData_ff;
  logic        answer_ff;

  // zero-based contents: each word follows from its address
  always_ff @(posedge clk_sys) begin
    answer_ff <= regRdReq_ff;
    if (regRdReq_ff) begin
      lastData_ff <= {regRdAddr_ff[7:0], regRdAddr_ff[15:8]} ^ 16'h5A3C;
    end
  end

  // valid only in the cycle after a request; elsewhere inverted so stale reads show up
  assign regRdData = answer_ff ? lastData_ff : ~lastData_ff;
endmodule : mtf_hold_regs

/* File: dv/modbus_tcp_server_framer_bench.sv */
`timescale 1ns/1ps

module modbus_tcp_server_framer_bench;
  // framer ports
  logic        clk_sys;
  logic        arst_n;
  logic        rxValid;
  logic [7:0]  rxData;
  logic        rxLast;
  logic [15:0] rxDstPort;
  logic        rxReady_ff;
  logic        txValid_ff;
  logic [7:0]  txData_ff;
  logic        txLast_ff;
  logic        txReady;
  logic        regRdReq_ff;
  logic [15:0] regRdAddr_ff;
  logic [15:0] regRdData;
  // bookkeeping
  int          fails;
  int          n_checks;
  logic [7:0]  rsp[$];

  mtf_framer dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .rxValid(rxValid), .rxData(rxData),
    .rxLast(rxLast), .rxDstPort(rxDstPort), .rxReady_ff(rxReady_ff),
    .txValid_ff(txValid_ff), .txData_ff(txData_ff), .txLast_ff(txLast_ff),
    .txReady(txReady), .regRdReq_ff(regRdReq_ff), .regRdAddr_ff(regRdAddr_ff),
    .regRdData(regRdData)
  );

  mtf_hold_regs regs (
    .clk_sys(clk_sys), .regRdReq_ff(regRdReq_ff), .regRdAddr_ff(regRdAddr_ff),
    .regRdData(regRdData)
  );

  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // mirror of the register model contents
  function automatic logic [15:0] reg_val(input logic [15:0] a);
    return {a[7:0], a[15:8]} ^ 16'h5A3C;
  endfunction : reg_val

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // inputs always move a fixed 2 ns after the rising edge
  task automatic step;
    @(posedge clk_sys);
    #2;
  endtask : step

  task automatic wait_fail(input string what);
    chk(what, 8'h01, 8'h00);
    stop_test();
  endtask : wait_fail

  // one request frame with length 6, each byte held until rxReady_ff takes it
  task automatic send(input logic [15:0] tid, pid, input logic [7:0] uid, fc,
                      input logic [15:0] ad, qt, input logic [15:0] port = 16'h01F6);
    logic [7:0] b[12];
    int t;
    b = '{tid[15:8], tid[7:0], pid[15:8], pid[7:0], 8'h00, 8'h06, uid, fc,
          ad[15:8], ad[7:0], qt[15:8], qt[7:0]};
    rxDstPort = port;
    foreach (b[i]) begin
      rxValid = 1'b1;
      rxData = b[i];
      rxLast = (i == 11);
      t = 0;
      while (rxReady_ff !== 1'b1) begin
        step();
        if (++t > 2000) wait_fail("rx ready");
      end
      step();
    end
    rxValid = 1'b0;
    rxLast = 1'b0;
  endtask : send

  // expected read answer: code, byte count, registers high byte first
  task automatic exp_read(input logic [15:0] ad, input int q);
    logic [15:0] v;
    rsp = {8'h03, 8'(2 * q)};
    for (int i = 0; i < q; i++) begin
      v = reg_val(ad + 16'(i));
      rsp.push_back(v[15:8]);
      rsp.push_back(v[7:0]);
    end
  endtask : exp_read

  task automatic exp_exc(input logic [7:0] fc, code);
    rsp = {fc | 8'h80, code};
  endtask : exp_exc

  // drain one response after a stall, header echoed and length recomputed
  task automatic recv(input logic [15:0] tid, pid, input logic [7:0] uid, input int stall);
    logic [7:0] exp[$];
    int t;
    int n;
    exp = {tid[15:8], tid[7:0], pid[15:8], pid[7:0], 8'h00, 8'(rsp.size() + 1), uid};
    exp = {exp, rsp};
    repeat (stall) step();
    txReady = 1'b1;
    n = 0;
    t = 0;
    while (n < exp.size()) begin
      if (txValid_ff === 1'b1) begin
        chk("tx byte", exp[n], txData_ff);
        chk("tx last", {7'h00, n == exp.size() - 1}, {7'h00, txLast_ff});
        n++;
      end
      step();
      if (++t > 3000) wait_fail("tx response");
    end
    txReady = 1'b0;
  endtask : recv

  task automatic t_walk;
    send(16'h0001, 16'h0000, 8'h00, 8'h03, 16'h0068, 16'h0002);
    exp_read(16'h0068, 2);
    recv(16'h0001, 16'h0000, 8'h00, 0);
  endtask : t_walk

  task automatic t_full_stall;
    send(16'hABCD, 16'h0000, 8'hFF, 8'h03, 16'h0000, 16'h007D);
    repeat (40) step();
    chk("rx held", 8'h00, {7'h00, rxReady_ff});
    exp_read(16'h0000, 125);
    recv(16'hABCD, 16'h0000, 8'hFF, 0);
  endtask : t_full_stall

  task automatic t_quantity;
    logic [15:0] q[3];
    q = '{16'h0000, 16'h007E, 16'hFFFF};
    foreach (q[i]) begin
      send(16'h0100 + 16'(i), 16'h0000, 8'h00, 8'h03, 16'h0010, q[i]);
      exp_exc(8'h03, 8'h03);
      recv(16'h0100 + 16'(i), 16'h0000, 8'h00, 3);
    end
    send(16'h0200, 16'h0000, 8'h00, 8'h03, 16'h00FF, 16'h0001);
    exp_read(16'h00FF, 1);
    recv(16'h0200, 16'h0000, 8'h00, 0);
    send(16'h0201, 16'h0000, 8'h00, 8'h03, 16'h00FF, 16'h0002);
    exp_exc(8'h03, 8'h02);
    recv(16'h0201, 16'h0000, 8'h00, 0);
  endtask : t_quantity

  task automatic t_func_codes;
    logic [7:0] f[7];
    f = '{8'h00, 8'h04, 8'h06, 8'h41, 8'h64, 8'h80, 8'hFF};
    foreach (f[i]) begin
      send(16'h0300 + 16'(i), 16'h0000, 8'h00, f[i], 16'h0000, 16'h0001);
      exp_exc(f[i], 8'h01);
      recv(16'h0300 + 16'(i), 16'h0000, 8'h00, 0);
    end
  endtask : t_func_codes

  // bad protocol id and foreign port are dropped, then service resumes
  task automatic t_drop;
    logic seen;
    seen = 1'b0;
    send(16'h0400, 16'h0001, 8'h00, 8'h03, 16'h0000, 16'h0001);
    send(16'h0401, 16'h0000, 8'h00, 8'h03, 16'h0000, 16'h0001, 16'h01F7);
    repeat (40) begin
      step();
      seen = seen | (txValid_ff !== 1'b0);
    end
    chk("dropped reply", 8'h00, {7'h00, seen});
    send(16'h0402, 16'h0000, 8'h00, 8'h03, 16'h0005, 16'h0001);
    exp_read(16'h0005, 1);
    recv(16'h0402, 16'h0000, 8'h00, 0);
  endtask : t_drop

  initial begin
    fails = 0;
    n_checks = 0;
    arst_n = 1'b0;
    rxValid = 1'b0;
    rxData = 8'h00;
    rxLast = 1'b0;
    rxDstPort = 16'h01F6;
    txReady = 1'b0;
    repeat (5) @(posedge clk_sys);
    #2;
    arst_n = 1'b1;
    step();
    t_walk();
    t_full_stall();
    t_quantity();
    t_func_codes();
    t_drop();
    stop_test();
  end
endmodule : modbus_tcp_server_framer_bench
